// *** xdes_top.sv ***
// Data-memory decode, stack pointer and three-byte data pointer.
// Assumes the core issues one request at a time and waits for its done pulse.
// Contract
// - Reset loads stack pointer low with 07H
// - Push pre-increments pointer, first byte at 08H
// - Map enable steers low 2K to RAM
// - Map disabled: every data move is external
// - Pointer above 0007FFH always goes external
// - Internal access leaves bus pins and strobes idle
// - Default stack is 8-bit, wraps FFH to 00H
// - Extended stack: 11 bits, FFH goes to 0100H
// - Extended stack uses only upper 1792 RAM bytes
// - Stack low at 81H, stack high at B7H
// - Stack high low three bits extend pointer
// - External addressing reaches 16 Mbytes, 24 bits
// - Pointer is three bytes, increment carries to page
// - External move generates all strobes itself
// - Special registers in upper 128, direct only
// - Indirect upper 128 reaches RAM, not registers
// - High port outputs middle and high address bytes
`timescale 1ns/1ns
module xdes_top
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Special-register access, direct addressing
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    output      logic [7:0]  sfr_rdata,
    output      logic        sfr_hit,
    // Stack operations
    input  wire logic        push,
    input  wire logic        pop,
    output      logic [10:0] stack_addr,
    output      logic        stack_in_extended_data_ram,
    // Internal data memory request
    input  wire logic        idata_indirect,
    input  wire logic [7:0]  idata_addr,
    output      logic        idata_to_ram,
    // Data pointer increment
    input  wire logic        dp_inc,
    output      logic [23:0] data_pointer,
    // Extended data move
    input  wire logic        xmove_req,
    input  wire logic        xmove_we,
    input  wire logic [7:0]  xmove_wdata,
    output      logic [7:0]  xmove_rdata,
    output      logic        xmove_done,
    // Multiplexed external bus
    output      logic [7:0]  low_address_data_port_out,
    output      logic        low_address_data_port_oe_n,
    input  wire logic [7:0]  low_address_data_port_in,
    output      logic [7:0]  high_address_port,
    output      logic        high_address_port_oe_n,
    output      logic        ale,
    output      logic        rd_n,
    output      logic        wr_n
);
    import xdes_pkg::*;

    xdes_ram_if ram ();

    xdes_ram u_ram
    (
        .sys_clk (sys_clk),
        .ram     (ram)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and pointers
    logic        extended_data_ram_map_enable_ff;
    logic        extended_stack_enable_ff;
    logic [7:0]  stack_pointer_low_ff;
    logic [2:0]  stack_pointer_high_ff;
    logic [7:0]  data_pointer_low_ff;
    logic [7:0]  data_pointer_high_ff;
    logic [7:0]  data_pointer_page_ff;
    logic [10:0] sp_full;
    logic [10:0] nxt_sp;
    logic        wr_sfr;

    // Direct addresses below 80H are RAM, never registers
    assign sfr_hit = sfr_addr >= SFR_BASE;
    assign wr_sfr  = sfr_wr && sfr_hit;
    assign idata_to_ram = idata_indirect || (idata_addr < SFR_BASE);

    // High bits masked at once when the long stack is off, not one cycle later
    assign sp_full = {extended_stack_enable_ff ? stack_pointer_high_ff : 3'h0, stack_pointer_low_ff};

    always_comb
    begin
        nxt_sp = sp_full;
        if (push)
        begin
            if (!extended_stack_enable_ff)
                nxt_sp = {3'h0, stack_pointer_low_ff + 8'h01};
            else if (sp_full == 11'h0ff)
                nxt_sp = XSTK_BASE;
            else
                nxt_sp = sp_full + 11'h001;
        end
        else if (pop)
        begin
            if (!extended_stack_enable_ff)
                nxt_sp = {3'h0, stack_pointer_low_ff - 8'h01};
            else if (sp_full == XSTK_BASE)
                nxt_sp = 11'h0ff;
            else
                nxt_sp = sp_full - 11'h001;
        end
    end

    // Pre-incremented pointer addresses the slot the push writes
    assign stack_addr    = push ? nxt_sp : sp_full;
    // Only 0100H and up in extended RAM, upper 1792 bytes
    assign stack_in_extended_data_ram = extended_stack_enable_ff && (stack_addr >= XSTK_BASE);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            extended_data_ram_map_enable_ff       <= 1'b0;
            extended_stack_enable_ff <= 1'b0;
        end
        else if (wr_sfr && sfr_addr == SFR_CONFIG)
        begin
            extended_data_ram_map_enable_ff       <= sfr_wdata[CFG_MAP_BIT];
            extended_stack_enable_ff <= sfr_wdata[CFG_XSTK_BIT];
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            stack_pointer_low_ff  <= RST_STACK_LOW;
            stack_pointer_high_ff <= RST_STACK_HIGH;
        end
        else if (wr_sfr && sfr_addr == SFR_STACK_LOW)
            stack_pointer_low_ff <= sfr_wdata;
        else if (wr_sfr && sfr_addr == SFR_STACK_HIGH)
            stack_pointer_high_ff <= extended_stack_enable_ff ? sfr_wdata[2:0] : 3'h0;
        else if (push || pop)
        begin
            stack_pointer_low_ff  <= nxt_sp[7:0];
            stack_pointer_high_ff <= nxt_sp[10:8];
        end
        else if (!extended_stack_enable_ff)
            stack_pointer_high_ff <= 3'h0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            data_pointer_low_ff  <= RST_DP;
            data_pointer_high_ff <= RST_DP;
            data_pointer_page_ff <= RST_DP;
        end
        else if (wr_sfr && sfr_addr == SFR_DP_LOW)
            data_pointer_low_ff <= sfr_wdata;
        else if (wr_sfr && sfr_addr == SFR_DP_HIGH)
            data_pointer_high_ff <= sfr_wdata;
        else if (wr_sfr && sfr_addr == SFR_DP_PAGE)
            data_pointer_page_ff <= sfr_wdata;
        else if (dp_inc)
            {data_pointer_page_ff, data_pointer_high_ff, data_pointer_low_ff} <= data_pointer + 24'h000001;
    end

    assign data_pointer = {data_pointer_page_ff, data_pointer_high_ff, data_pointer_low_ff};

    always_comb
    begin
        sfr_rdata = 8'h00;
        if (sfr_rd && sfr_hit)
        begin
            case (sfr_addr)
                SFR_STACK_LOW:  sfr_rdata = stack_pointer_low_ff;
                SFR_STACK_HIGH: sfr_rdata = {5'h00, sp_full[10:8]};
                SFR_DP_LOW:     sfr_rdata = data_pointer_low_ff;
                SFR_DP_HIGH:    sfr_rdata = data_pointer_high_ff;
                SFR_DP_PAGE:    sfr_rdata = data_pointer_page_ff;
                SFR_CONFIG:     sfr_rdata = {extended_stack_enable_ff, 6'h00, extended_data_ram_map_enable_ff};
                default:        sfr_rdata = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Extended data move decode
    logic        to_extended_data_ram;
    logic        int_busy_ff;
    xdes_bus_t   bus_ff;
    logic [1:0]  cnt_ff;
    logic        mv_we_ff;
    logic [7:0]  mv_wdata_ff;
    logic [23:0] mv_addr_ff;
    logic [7:0]  rdata_ff;
    logic        done_ff;

    // Map bit clear or pointer above the 2K window means external
    assign to_extended_data_ram = extended_data_ram_map_enable_ff && (data_pointer <= EXTENDED_DATA_RAM_LAST);

    assign ram.req   = xmove_req && to_extended_data_ram && bus_ff == XDES_IDLE && !int_busy_ff;
    assign ram.we    = xmove_we;
    assign ram.addr  = data_pointer[10:0];
    assign ram.wdata = xmove_wdata;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            int_busy_ff <= 1'b0;
        else
            int_busy_ff <= ram.req;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bus_ff      <= XDES_IDLE;
            cnt_ff      <= 2'h0;
            mv_we_ff    <= 1'b0;
            mv_wdata_ff <= 8'h00;
            mv_addr_ff  <= 24'h000000;
        end
        else
        begin
            case (bus_ff)
                XDES_IDLE:
                begin
                    if (xmove_req && !to_extended_data_ram && !int_busy_ff)
                    begin
                        bus_ff      <= XDES_ADDR;
                        mv_we_ff    <= xmove_we;
                        mv_wdata_ff <= xmove_wdata;
                        mv_addr_ff  <= data_pointer;
                    end
                end
                XDES_ADDR:
                begin
                    bus_ff <= XDES_STROB;
                    cnt_ff <= 2'(EXT_CYCLES - 1);
                end
                XDES_STROB:
                begin
                    if (cnt_ff == 2'h0)
                        bus_ff <= XDES_DONE;
                    else
                        cnt_ff <= cnt_ff - 2'h1;
                end
                XDES_DONE: bus_ff <= XDES_IDLE;
                default:   bus_ff <= XDES_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 8'h00;
            done_ff  <= 1'b0;
        end
        else
        begin
            done_ff <= int_busy_ff || (bus_ff == XDES_DONE);
            if (int_busy_ff)
                rdata_ff <= ram.rdata;
            else if (bus_ff == XDES_STROB && cnt_ff == 2'h0 && !mv_we_ff)
                rdata_ff <= low_address_data_port_in;
        end
    end

    assign xmove_rdata = rdata_ff;
    assign xmove_done  = done_ff;

    // Pins stay released unless an external cycle runs; internal moves never touch them
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            low_address_data_port_out  <= 8'hff;
            low_address_data_port_oe_n <= 1'b1;
            high_address_port          <= 8'hff;
            high_address_port_oe_n     <= 1'b1;
            ale                        <= 1'b0;
            rd_n                       <= 1'b1;
            wr_n                       <= 1'b1;
        end
        else
        begin
            ale  <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            low_address_data_port_oe_n <= 1'b1;
            high_address_port_oe_n     <= 1'b1;
            if (bus_ff == XDES_IDLE && xmove_req && !to_extended_data_ram && !int_busy_ff)
            begin
                // Page byte and low byte are driven in the same cycle and latched while ale is high
                ale                        <= 1'b1;
                low_address_data_port_out  <= data_pointer[7:0];
                low_address_data_port_oe_n <= 1'b0;
                high_address_port          <= data_pointer[23:16];
                high_address_port_oe_n     <= 1'b0;
            end
            else if (bus_ff == XDES_ADDR || (bus_ff == XDES_STROB && cnt_ff != 2'h0))
            begin
                high_address_port          <= mv_addr_ff[15:8];
                high_address_port_oe_n     <= 1'b0;
                rd_n                       <= mv_we_ff;
                wr_n                       <= !mv_we_ff;
                low_address_data_port_out  <= mv_wdata_ff;
                low_address_data_port_oe_n <= !mv_we_ff;
            end
        end
    end
endmodule // xdes_top

// *** xdes_pkg.sv ***
// Package for the data-memory decode and extended stack block.
// Assumes a core that presents special-register and data-move requests as one-cycle pulses.
package xdes_pkg;
    localparam logic [7:0]  SFR_STACK_LOW      = 8'h81;
    localparam logic [7:0]  SFR_STACK_HIGH     = 8'hb7;
    localparam logic [7:0]  SFR_DP_LOW         = 8'h82;
    localparam logic [7:0]  SFR_DP_HIGH        = 8'h83;
    localparam logic [7:0]  SFR_DP_PAGE        = 8'h84;
    localparam logic [7:0]  SFR_CONFIG         = 8'haf;
    localparam logic [7:0]  SFR_BASE           = 8'h80;
    localparam int          CFG_MAP_BIT        = 0;
    localparam int          CFG_XSTK_BIT       = 7;
    localparam logic [7:0]  RST_STACK_LOW      = 8'h07;
    localparam logic [2:0]  RST_STACK_HIGH     = 3'h0;
    localparam logic [7:0]  RST_DP             = 8'h00;
    localparam logic [23:0] EXTENDED_DATA_RAM_LAST          = 24'h0007ff;
    localparam int          EXTENDED_DATA_RAM_AW            = 11;
    localparam logic [10:0] XSTK_BASE          = 11'h100;
    localparam int          EXT_CYCLES         = 4;

    typedef enum logic [1:0]
    {
        XDES_IDLE  = 2'b00,
        XDES_ADDR  = 2'b01,
        XDES_STROB = 2'b10,
        XDES_DONE  = 2'b11
    } xdes_bus_t;
endpackage

// *** xdes_ram_if.sv ***
// Interface between the decode logic and the on-chip extended RAM.
// Assumes one clock; read data arrive one cycle after the request.
`timescale 1ns/1ns
interface xdes_ram_if;
    logic        req;
    logic        we;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    modport ctl (output req, output we, output addr, output wdata, input rdata);
    modport mem (input req, input we, input addr, input wdata, output rdata);
endinterface

// *** xdes_ram.sv ***
// On-chip extended RAM, 2 Kbytes, registered read data.
// Assumes synchronous single-port use from the decode logic.
`timescale 1ns/1ns
module xdes_ram
(
    // Clock
    input wire logic sys_clk,
    // Access
    xdes_ram_if.mem  ram
);
    import xdes_pkg::*;
    logic [7:0] mem_ff [0:(1<<EXTENDED_DATA_RAM_AW)-1];
    logic [7:0] rdata_ff;

    always_ff @(posedge sys_clk)
    begin
        if (ram.req && ram.we)
            mem_ff[ram.addr] <= ram.wdata;
    end

    always_ff @(posedge sys_clk)
    begin
        if (ram.req && !ram.we)
            rdata_ff <= mem_ff[ram.addr];
    end

    assign ram.rdata = rdata_ff;
endmodule // xdes_ram

// *** xdes_top_properties.sv ***
// Checker on the ports of the data-memory decode block.
// Assumes config and data pointer stay put while a move is in flight.
`timescale 1ns/1ns
module xdes_top_properties
(
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Core side
    input wire logic        sfr_wr,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        push,
    input wire logic [10:0] stack_addr,
    input wire logic        stack_in_extended_data_ram,
    input wire logic        dp_inc,
    input wire logic [23:0] data_pointer,
    input wire logic        xmove_req,
    input wire logic        xmove_done,
    // External bus
    input wire logic [7:0]  low_address_data_port_out,
    input wire logic        low_address_data_port_oe_n,
    input wire logic [7:0]  high_address_port,
    input wire logic        high_address_port_oe_n,
    input wire logic        ale,
    input wire logic        rd_n,
    input wire logic        wr_n
);
    import xdes_pkg::*;
    logic map_ff;
    logic xstk_ff;
    logic inr;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Mirror of the config bits, so the decode is predictable from the ports
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            {map_ff, xstk_ff} <= 2'b00;
        else if (sfr_wr && sfr_addr == SFR_CONFIG)
            {map_ff, xstk_ff} <= {sfr_wdata[CFG_MAP_BIT], sfr_wdata[CFG_XSTK_BIT]};
    end
    assign inr = map_ff && (data_pointer <= EXTENDED_DATA_RAM_LAST);
    ////////////////////////////////////////////////////////////////
    chk_sp_reset: assert property (!$past(rst_n) && !push |-> stack_addr == 11'h007)
        else $error("stack pointer not 07 after reset");
    chk_push_hold: assert property (push && !sfr_wr ##1 !push && !sfr_wr |-> stack_addr == $past(stack_addr))
        else $error("push is not a pre-increment");
    chk_wrap_eight: assert property (!xstk_ff && !push && !sfr_wr && stack_addr == 11'h0ff
        ##1 push |-> stack_addr == 11'h000)
        else $error("short stack wrap wrong");
    chk_wrap_eleven: assert property (xstk_ff && !push && !sfr_wr && stack_addr == 11'h0ff
        ##1 push |-> stack_addr == XSTK_BASE && stack_in_extended_data_ram)
        else $error("long stack wrap wrong");
    chk_high_zero: assert property (!xstk_ff |-> stack_addr[10:8] == 3'h0 && !stack_in_extended_data_ram)
        else $error("stack high bits set");
    chk_int_done: assert property ($rose(xmove_req) && inr |-> ##2 xmove_done)
        else $error("internal move late");
    chk_int_quiet: assert property (xmove_req && inr |-> rd_n && wr_n && !ale
        && low_address_data_port_oe_n && high_address_port_oe_n)
        else $error("bus active on internal move");
    chk_ext_addr: assert property ($rose(xmove_req) && !inr |=> ale && !low_address_data_port_oe_n
        && low_address_data_port_out == data_pointer[7:0] && high_address_port == data_pointer[23:16])
        else $error("address phase wrong");
    chk_ext_strobe: assert property ($rose(xmove_req) && !inr |-> ##2
        (rd_n != wr_n && high_address_port == data_pointer[15:8])[*4] ##1 rd_n && wr_n)
        else $error("strobe phase wrong");
    // Done is registered off the done state, so it is seen seven edges after the request
    chk_ext_done: assert property ($rose(xmove_req) && !inr |-> ##7 xmove_done)
        else $error("external move late");
    chk_dp_carry: assert property (dp_inc && !sfr_wr |=> data_pointer == $past(data_pointer) + 24'h000001)
        else $error("pointer increment wrong");
    cover property ($rose(xmove_req) && inr);
    cover property ($rose(xmove_req) && !inr);
    cover property (push && stack_in_extended_data_ram);
endmodule // xdes_top_properties

bind xdes_top xdes_top_properties u_props
(
    .sys_clk(sys_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .push(push), .stack_addr(stack_addr), .stack_in_extended_data_ram(stack_in_extended_data_ram), .dp_inc(dp_inc),
    .data_pointer(data_pointer), .xmove_req(xmove_req), .xmove_done(xmove_done),
    .low_address_data_port_out(low_address_data_port_out), .high_address_port(high_address_port),
    .low_address_data_port_oe_n(low_address_data_port_oe_n), .high_address_port_oe_n(high_address_port_oe_n),
    .ale(ale), .rd_n(rd_n), .wr_n(wr_n)
);

// *** xdes_ext_mem.sv ***
// Behavioural external data memory on the multiplexed bus.
// Assumes one clock; 256 cells, the three address bytes folded into one index.
`timescale 1ns/1ns
module xdes_ext_mem
(
    // Clock
    input  wire logic       sys_clk,
    // Bus from the device
    input  wire logic [7:0] port_out,
    input  wire logic [7:0] high_port,
    input  wire logic       ale,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // Data back to the device
    output      logic [7:0] port_in
);
    logic [7:0] mem [256];
    logic [7:0] lo_ff;
    logic [7:0] pg_ff;
    logic [7:0] idx;
    assign idx = lo_ff ^ pg_ff ^ high_port;
    always @(posedge sys_clk)
    begin
        if (ale)
        begin
            lo_ff <= port_out;
            pg_ff <= high_port;
        end
        if (!wr_n)
            mem[idx] <= port_out;
    end
    // Released bus toggles every half cycle, so a stale byte cannot pass
    assign port_in = rd_n ? ({8{sys_clk}} ^ 8'ha5) : mem[idx];
endmodule // xdes_ext_mem

// *** tb.sv ***
// Self-checking bench for the data-memory decode block.
// Assumes package, design, checker and bus model are compiled first.
`timescale 1ns/1ns
module tb;
    import xdes_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        sfr_wr = 1'b0, sfr_rd = 1'b0, push = 1'b0, pop = 1'b0, dp_inc = 1'b0, ale_q = 1'b0;
    logic        idata_indirect = 1'b0, xmove_req = 1'b0, xmove_we = 1'b0, cur_rd = 1'b0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, idata_addr = 8'h00, xmove_wdata = 8'h00, rnd = 8'h5b;
    logic [7:0]  sfr_rdata, xmove_rdata, p0_out, p0_in, p2_out;
    logic        sfr_hit, stack_in_extended_data_ram, idata_to_ram, xmove_done, p0_oe_n, p2_oe_n, ale, rd_n, wr_n;
    logic [10:0] stack_addr;
    logic [23:0] data_pointer;
    logic [7:0]  exp_q[$];
    int          n_errors = 0, check_count = 0, n_ale = 0, base = 0;
    xdes_top uut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .push(push), .pop(pop),
        .stack_addr(stack_addr), .stack_in_extended_data_ram(stack_in_extended_data_ram), .idata_indirect(idata_indirect),
        .idata_addr(idata_addr), .idata_to_ram(idata_to_ram), .dp_inc(dp_inc), .data_pointer(data_pointer),
        .xmove_req(xmove_req), .xmove_we(xmove_we), .xmove_wdata(xmove_wdata), .xmove_rdata(xmove_rdata),
        .xmove_done(xmove_done), .low_address_data_port_out(p0_out), .low_address_data_port_oe_n(p0_oe_n),
        .low_address_data_port_in(p0_in), .high_address_port(p2_out), .high_address_port_oe_n(p2_oe_n),
        .ale(ale), .rd_n(rd_n), .wr_n(wr_n)
    );
    xdes_ext_mem u_mem
    (
        .sys_clk(sys_clk), .port_out(p0_out), .high_port(p2_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
        .port_in(p0_in)
    );
    always #2 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(input logic [23:0] exp, input logic [23:0] got);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tick;
        @(posedge sys_clk);
        #1;
    endtask
    task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
        tick;
        sfr_wr = 1'b1;
        sfr_addr = a;
        sfr_wdata = d;
        tick;
        sfr_wr = 1'b0;
    endtask
    task automatic sfr_r(input logic [7:0] a, input logic [7:0] exp);
        tick;
        sfr_rd = 1'b1;
        sfr_addr = a;
        #1;
        chk({16'h0, exp}, {16'h0, sfr_rdata});
        tick;
        sfr_rd = 1'b0;
    endtask
    task automatic stk(input logic [10:0] exp);
        tick;
        push = 1'b1;
        #1;
        chk({13'h0, exp}, {13'h0, stack_addr});
        tick;
        push = 1'b0;
    endtask
    // Write a random byte, read it back; n_ext is the expected count of address phases
    task automatic xrw(input logic [23:0] a, input int n_ext);
        int i;
        sfr_w(SFR_DP_PAGE, a[23:16]);
        sfr_w(SFR_DP_HIGH, a[15:8]);
        sfr_w(SFR_DP_LOW, a[7:0]);
        base = n_ale;
        for (int w = 1; w >= 0; w--)
        begin
            tick;
            xmove_req = 1'b1;
            xmove_we = w[0];
            xmove_wdata = rnd;
            cur_rd = !w[0];
            if (w == 0)
                exp_q.push_back(rnd);
            for (i = 0; i < 20 && xmove_done !== 1'b1; i++)
                tick;
            xmove_req = 1'b0;
            if (i == 20)
            begin
                n_errors++;
                wrap_up;
            end
        end
        rnd = lfsr(rnd);
        chk(24'(n_ext), 24'(n_ale - base));
    endtask
    always @(negedge sys_clk)
    begin
        if (ale === 1'b1 && ale_q !== 1'b1)
            n_ale++;
        ale_q = ale;
        if (xmove_done === 1'b1 && cur_rd && exp_q.size() > 0)
            chk({16'h0, exp_q.pop_front()}, {16'h0, xmove_rdata});
        else if (xmove_done === 1'b1 && cur_rd)
        begin
            n_errors++;
            $display("mismatch at %0t: read result with no expectation", $time);
        end
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        chk(24'h000007, {13'h0, stack_addr});
        sfr_r(SFR_STACK_LOW, RST_STACK_LOW);
        sfr_r(SFR_CONFIG, 8'h00);
        stk(11'h008);
        sfr_r(SFR_STACK_LOW, 8'h08);
        sfr_w(SFR_STACK_HIGH, 8'h05);
        sfr_r(SFR_STACK_HIGH, 8'h00);
        sfr_w(SFR_STACK_LOW, 8'hff);
        stk(11'h000);
        sfr_w(SFR_CONFIG, 8'h80);
        sfr_w(SFR_STACK_LOW, 8'hff);
        stk(11'h100);
        // Pop out of the extended region falls back to the top of internal RAM
        tick;
        pop = 1'b1;
        tick;
        pop = 1'b0;
        chk(24'h0000ff, {13'h0, stack_addr});
        sfr_w(SFR_STACK_HIGH, 8'h07);
        sfr_r(SFR_STACK_HIGH, 8'h07);
        chk(24'h0007ff, {13'h0, stack_addr});
        sfr_w(SFR_STACK_HIGH, 8'h00);
        sfr_w(SFR_CONFIG, 8'h00);
        sfr_r(8'hb0, 8'h00);
        sfr_r(8'h10, 8'h00);
        chk(24'h0, {23'h0, sfr_hit});
        for (int k = 0; k < 4; k++)
        begin
            tick;
            idata_indirect = k[0];
            idata_addr = k[1] ? 8'hc0 : 8'h40;
            #1;
            chk({23'h0, !k[1] || k[0]}, {23'h0, idata_to_ram});
        end
        xrw(24'h000010, 2);
        sfr_w(SFR_CONFIG, 8'h01);
        xrw(24'h0007ff, 0);
        xrw(24'h000800, 2);
        xrw(24'hab1234, 2);
        xrw(24'h000000, 0);
        sfr_w(SFR_DP_HIGH, 8'hff);
        sfr_w(SFR_DP_LOW, 8'hff);
        tick;
        dp_inc = 1'b1;
        tick;
        dp_inc = 1'b0;
        chk(24'h010000, data_pointer);
        sfr_r(SFR_DP_PAGE, 8'h01);
        wrap_up;
    end
endmodule // tb
